/* dv/ldcd_checker.sv */
/*
  Checker for the configuration bank: power-up values, boot load, store and recall pulses.
  Assumes it is bound to ldcd_top and sees only its ports.
*/
`timescale 1ns/1ps
module ldcd_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Memory port.
  input wire logic nvm_rd,
  input wire logic nvm_wr,
  input wire logic [6:0] nvm_addr,
  // Configuration values.
  input wire logic [7:0] string_enable,
  input wire logic [7:0] power_config,
  input wire logic [7:0] oscillator_select,
  input wire logic [7:0] overtemp_threshold,
  input wire logic [7:0] system_temperature,
  input wire logic [7:0] overtemp_derate_slope,
  input wire logic [7:0] pulse_width_config,
  input wire logic [7:0] global_brightness,
  input wire logic [7:0] grayscale_clock_divider,
  input wire logic [7:0] frame_sync_multiplier,
  input wire logic [7:0] optimizer_monitor_low,
  input wire logic [7:0] optimizer_monitor_high,
  // Status.
  input wire logic boot_load_active_flag,
  input wire logic nvm_busy_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_defaults_first: assert property (
    $rose(rst_b) |-> string_enable == 8'hff && power_config == 8'h77
      && oscillator_select == 8'h04 && overtemp_threshold == 8'h5a)
    else $error("first group of power-up values wrong");
  a_defaults_second: assert property (
    $rose(rst_b) |-> system_temperature == 8'h1e && overtemp_derate_slope == 8'h32
      && pulse_width_config == 8'h71 && global_brightness == 8'h0f)
    else $error("second group of power-up values wrong");
  a_defaults_third: assert property (
    $rose(rst_b) |-> grayscale_clock_divider == 8'h00 && frame_sync_multiplier == 8'h01
      && optimizer_monitor_low == 8'hff && optimizer_monitor_high == 8'hff)
    else $error("third group of power-up values wrong");
  a_boot_read: assert property (
    $rose(rst_b) |-> ##[0:2] (nvm_rd && nvm_addr == 7'h00))
    else $error("boot load did not start at address zero");
  a_boot_span: assert property (
    $rose(rst_b) |-> boot_load_active_flag [*8] ##[12:24] !boot_load_active_flag)
    else $error("boot load length wrong");
  a_boot_quiet: assert property (
    boot_load_active_flag |-> !nvm_wr && nvm_busy_flag)
    else $error("store or idle status during boot load");
  a_store_pulse: assert property (
    nvm_wr |=> !nvm_wr ##0 nvm_busy_flag [*8])
    else $error("store pulse or busy wrong");
  a_recall_pulse: assert property (
    nvm_rd && !boot_load_active_flag |-> !nvm_wr ##1 !nvm_rd)
    else $error("recall pulse wrong");
  c_store: cover property (nvm_wr);
  c_recall: cover property (nvm_rd && !boot_load_active_flag);
  c_boot_done: cover property ($fell(boot_load_active_flag));
endmodule

bind ldcd_top ldcd_checker i_ldcd_checker (
  .clk, .rst_b, .nvm_rd, .nvm_wr, .nvm_addr, .string_enable, .power_config,
  .oscillator_select, .overtemp_threshold, .system_temperature, .overtemp_derate_slope,
  .pulse_width_config, .global_brightness, .grayscale_clock_divider, .frame_sync_multiplier,
  .optimizer_monitor_low, .optimizer_monitor_high, .boot_load_active_flag, .nvm_busy_flag
);

/* dv/ldcd_host_model.sv */
/*
  Host model: a two-wire bus master that writes and reads single registers.
  Assumes a pull-up on the data line and a device that keeps the bus timing.
*/
`timescale 1ns/1ps
module ldcd_host_model #(
  parameter logic [6:0] DEV = 7'h2a
) (
  // Clock.
  input wire logic clk,
  // Bus lines.
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic host_low;
  // Pull-up: the line is high unless one party pulls it low.
  assign sda = !(host_low || (sda_oe && !sda_out));
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  task automatic step(input logic c, input logic lo);
    scl = c;
    host_low = lo;
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, (i > 0) ? !d[i-1] : 1'b0);
      step(1'b1, (i > 0) ? !d[i-1] : 1'b0);
      if (i > 0) begin
        q[i-1] = sda;
      end else begin
        ack = !sda;
      end
      step(1'b0, (i > 0) ? !d[i-1] : 1'b0);
    end
  endtask
  task automatic start();
    step(scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // Callers reach into the reserved address hole only at the readback, 0x59.
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd,
                      output logic [7:0] q, output logic ok);
    logic k1, k2, k3;
    start();
    byte_io({DEV, 1'b0}, q, k1);
    byte_io(a, q, k2);
    if (rd) begin
      start();
      byte_io({DEV, 1'b1}, q, k3);
      byte_io(8'hff, q, ok);
    end else begin
      byte_io(d, q, k3);
    end
    stop();
    ok = k1 && k2 && k3;
  endtask
endmodule

/* dv/ldcd_top_bench.sv */
/*
  Testbench for the configuration bank: defaults, boot load, read-only readback,
  writes, store and recall. Assumes a memory whose read data follows its address
  in the same cycle.
*/
`timescale 1ns/1ps
module ldcd_top_bench;
  import ldcd_pkg::*;
  logic clk, rst_b, scl, sda, sda_oe, sda_out, nvm_rd, nvm_wr, boot, busy, dac_act, ok;
  logic [3:0] dac_code;
  logic [6:0] nvm_addr;
  logic [7:0] nvm_wdata, nvm_rdata, q;
  logic [7:0] mem [128];
  ldcd_cfg_t cfg;
  int num_errors, comparisons;
  ldcd_top i_ldcd_top (
    .clk, .rst_b, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .optimizer_dac_code(dac_code), .optimizer_active_flag(dac_act),
    .nvm_rd, .nvm_wr, .nvm_addr, .nvm_wdata, .nvm_rdata,
    .string_enable(cfg[0]), .power_config(cfg[1]), .oscillator_select(cfg[2]),
    .overtemp_threshold(cfg[3]), .system_temperature(cfg[4]),
    .overtemp_derate_slope(cfg[5]), .pulse_width_config(cfg[6]),
    .global_brightness(cfg[7]), .grayscale_clock_divider(cfg[8]),
    .frame_sync_multiplier(cfg[9]), .optimizer_monitor_low(cfg[10]),
    .optimizer_monitor_high(cfg[11]), .boot_load_active_flag(boot), .nvm_busy_flag(busy)
  );
  ldcd_host_model i_ldcd_host_model (.clk, .sda_oe, .sda_out, .scl, .sda);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  assign nvm_rdata = mem[nvm_addr];
  always @(posedge clk) begin
    if (nvm_wr) mem[nvm_addr] <= nvm_wdata;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ldcd_host_model.xfer(a, d, 1'b0, q, ok);
    cmp(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_ldcd_host_model.xfer(a, 8'h00, 1'b1, q, ok);
    cmp(ok, 1'b1);
    cmp(q, exp);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 3000 && (busy || boot); n++) @(posedge clk);
    #1;
    if (busy !== 1'b0) begin
      $display("CHECK FAILED %0t busy did not clear", $time);
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_defaults();
    for (int i = 0; i < CFG_NUM; i++) begin
      cmp(cfg[i], CFG_DEFAULT[i]);
    end
  endtask
  task automatic check_boot();
    rst_b = 1'b1;
    wait_idle();
    for (int i = 0; i < CFG_NUM; i++) cmp(cfg[i], ~CFG_DEFAULT[i] & CFG_MASK[i]);
  endtask
  task automatic check_readonly();
    wr(OFS_DAC_READBACK, 8'h00);
    rd(OFS_DAC_READBACK, 8'h8a);
  endtask
  task automatic check_store_recall();
    wr(8'h0b, 8'h20);
    cmp(cfg[7], 8'h20);
    wr(OFS_NVM_ADDRESS, 8'h0b);
    wr(OFS_NVM_CONTROL, 8'h02);
    wait_idle();
    cmp(mem[7'h0b], 8'h20);
    wr(8'h0b, 8'h05);
    wr(OFS_NVM_CONTROL, 8'h01);
    wait_idle();
    cmp(cfg[7], 8'h20);
    wr(OFS_NVM_ADDRESS, 8'h07);
    wr(OFS_NVM_CONTROL, 8'h01);
    wait_idle();
    rd(OFS_NVM_CONTROL, 8'h20);
  endtask
  initial begin
    rst_b = 1'b0;
    dac_code = 4'ha;
    dac_act = 1'b1;
    num_errors = 0;
    comparisons = 0;
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    for (int i = 0; i < CFG_NUM; i++) mem[CFG_OFFSET[i][6:0]] = ~CFG_DEFAULT[i];
    repeat (16) @(posedge clk);
    #1;
    check_defaults();
    check_boot();
    check_readonly();
    check_store_recall();
    end_of_test();
  end
endmodule

/* hdl/ldcd_pkg.sv */
/*
  Constants for the LED driver configuration register bank: register offsets,
  field positions, power-up values, write masks, nonvolatile memory timing and
  the serial-port states.
  Assumes a 200 MHz system clock and a single-cycle-read nonvolatile memory.
*/
package ldcd_pkg;

  localparam int CFG_NUM = 12;
  typedef logic [CFG_NUM-1:0][7:0] ldcd_cfg_t;

  // Offsets of the loadable configuration registers, entry 11 first.
  localparam ldcd_cfg_t CFG_OFFSET = {8'h0f, 8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h08,
                                      8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h00};
  // Values held until the nonvolatile load replaces them.
  localparam ldcd_cfg_t CFG_DEFAULT = {8'hff, 8'hff, 8'h01, 8'h00, 8'h0f, 8'h71,
                                       8'h32, 8'h1e, 8'h5a, 8'h04, 8'h77, 8'hff};
  // Implemented bits of each register; the rest read as zero after a write, boot load or recall.
  localparam ldcd_cfg_t CFG_MASK = {8'hff, 8'hff, 8'h1f, 8'h0f, 8'h7f, 8'hff,
                                    8'hff, 8'hff, 8'hff, 8'h07, 8'hbf, 8'hff};

  localparam logic [7:0] OFS_DAC_READBACK = 8'h59;
  localparam logic [7:0] OFS_NVM_ADDRESS = 8'h90;
  localparam logic [7:0] OFS_NVM_CONTROL = 8'h91;
  localparam logic [7:0] HOLE_FIRST = 8'h58;
  localparam logic [7:0] HOLE_LAST = 8'h8f;

  localparam int DAC_ACTIVE_BIT = 7;
  localparam int NVM_BUSY_BIT = 7;
  localparam int NVM_BOOT_BIT = 6;
  localparam int NVM_ERR_BIT = 5;
  localparam int NVM_STORE_BIT = 1;
  localparam int NVM_RECALL_BIT = 0;
  localparam logic [7:0] NVM_ADDRESS_RESET = 8'h00;

  localparam int CLK_PERIOD_NS = 5;
  localparam int NVM_WRITE_TIME_US = 10;
  localparam int NVM_WRITE_CYCLES = (NVM_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
  localparam int BUSY_W = 16;

  typedef enum logic [6:0] {
    I2C_IDLE = 7'b0000001,
    I2C_ADDR = 7'b0000010,
    I2C_AACK = 7'b0000100,
    I2C_WR   = 7'b0001000,
    I2C_WACK = 7'b0010000,
    I2C_RD   = 7'b0100000,
    I2C_RACK = 7'b1000000
  } ldcd_i2c_e;

endpackage

/* hdl/ldcd_top.sv */
/*
  Configuration register bank of an eight-string LED driver, reached over the
  two-wire serial port, with power-up load of its values from nonvolatile memory
  and host store and recall through the user memory registers.
  Assumes scl and sda arrive from pins, the optimizer readback from an analog
  block, and a nonvolatile memory whose read data stands in the cycle rd is high.
*/
// Operation
// - Power-up loads configuration registers from nonvolatile memory.
// - String enables default to all eight on.
// - Power configuration defaults to 0x77, device awake.
// - Oscillator select defaults to code 4, 20MHz.
// - Over-temperature threshold defaults to 90 degrees.
// - System temperature defaults to 30 degrees.
// - Derating slope defaults to 50 degrees.
// - Pulse-width configuration defaults to 0x71.
// - Global brightness defaults to 15 of 128.
// - Grayscale clock divider defaults to no division.
// - Frame-sync multiplier defaults to one.
// - Both optimizer monitor registers default to 0xFF.
// - Registers 0x90, 0x91 reach user nonvolatile memory.
`timescale 1ns/1ps
module ldcd_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Serial port pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Optimizer converter status from the analog side.
  input wire logic [3:0] optimizer_dac_code,
  input wire logic optimizer_active_flag,
  // Nonvolatile memory port.
  output logic nvm_rd,
  output logic nvm_wr,
  output logic [6:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  input wire logic [7:0] nvm_rdata,
  // Configuration values for the rest of the device.
  output logic [7:0] string_enable,
  output logic [7:0] power_config,
  output logic [7:0] oscillator_select,
  output logic [7:0] overtemp_threshold,
  output logic [7:0] system_temperature,
  output logic [7:0] overtemp_derate_slope,
  output logic [7:0] pulse_width_config,
  output logic [7:0] global_brightness,
  output logic [7:0] grayscale_clock_divider,
  output logic [7:0] frame_sync_multiplier,
  output logic [7:0] optimizer_monitor_low,
  output logic [7:0] optimizer_monitor_high,
  // Status.
  output logic boot_load_active_flag,
  output logic nvm_busy_flag
);
  import ldcd_pkg::*;

  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_addr_check
    $error("Device address lies in a reserved range.");
  end

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [4:0] dac_s0;
    logic [4:0] dac_s1;
    ldcd_i2c_e i2c;
    logic [2:0] bit_cnt;
    logic full;
    logic first;
    logic rw;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    ldcd_cfg_t cfg;
    logic [6:0] user_addr;
    logic err;
    logic boot;
    logic recall;
    logic [3:0] idx;
    logic phase;
    logic nvm_rd;
    logic nvm_wr;
    logic [6:0] nvm_a;
    logic [7:0] nvm_wd;
    logic [BUSY_W-1:0] busy_cnt;
    logic busy;
  } ldcd_state_s;

  ldcd_state_s st_ff;
  ldcd_state_s nxt_st;

  function automatic logic [4:0] cfg_lookup(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < CFG_NUM; i++) begin
      if (CFG_OFFSET[i] == a) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] read_reg(input ldcd_state_s s, input logic [7:0] a);
    logic [4:0] hit;
    logic [7:0] d;
    hit = cfg_lookup(a);
    d = 8'h00;
    if (hit[4]) begin
      d = s.cfg[hit[3:0]];
    end else if (a == OFS_DAC_READBACK) begin
      d = {s.dac_s1[4], 3'h0, s.dac_s1[3:0]};
    end else if (a == OFS_NVM_ADDRESS) begin
      d = {1'b0, s.user_addr};
    end else if (a == OFS_NVM_CONTROL) begin
      d[NVM_BUSY_BIT] = s.busy;
      d[NVM_BOOT_BIT] = s.boot;
      d[NVM_ERR_BIT] = s.err;
    end
    return d;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic sda_now;
  logic [7:0] rd_data;
  logic [4:0] hit;
  logic set_err;
  logic [6:0] op_addr;
  logic [4:0] op_hit;

  always_comb begin
    nxt_st = st_ff;
    sda_now = st_ff.sda_s[1];
    scl_rise = st_ff.scl_s[1] && !st_ff.scl_s[2];
    scl_fall = !st_ff.scl_s[1] && st_ff.scl_s[2];
    start_cond = st_ff.scl_s[1] && st_ff.scl_s[2] && !st_ff.sda_s[1] && st_ff.sda_s[2];
    stop_cond = st_ff.scl_s[1] && st_ff.scl_s[2] && st_ff.sda_s[1] && !st_ff.sda_s[2];
    rd_data = 8'h00;
    hit = 5'h00;
    set_err = 1'b0;
    op_addr = st_ff.user_addr;
    op_hit = cfg_lookup({1'b0, op_addr});
    nxt_st.scl_s = {st_ff.scl_s[1:0], scl_in};
    nxt_st.sda_s = {st_ff.sda_s[1:0], sda_in};
    nxt_st.dac_s0 = {optimizer_active_flag, optimizer_dac_code};
    nxt_st.dac_s1 = st_ff.dac_s0;
    nxt_st.nvm_rd = 1'b0;
    nxt_st.nvm_wr = 1'b0;
    nxt_st.sda_out = 1'b0;
    if (st_ff.busy_cnt != '0) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - 1'b1;
    end
    if (start_cond) begin
      nxt_st.i2c = I2C_ADDR;
      nxt_st.bit_cnt = 3'h0;
      nxt_st.full = 1'b0;
      nxt_st.first = 1'b1;
      nxt_st.sda_oe = 1'b0;
    end else if (stop_cond) begin
      nxt_st.i2c = I2C_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else begin
      unique case (st_ff.i2c)
        I2C_IDLE: begin
          nxt_st.sda_oe = 1'b0;
        end
        I2C_ADDR, I2C_WR: begin
          if (scl_rise) begin
            nxt_st.shreg = {st_ff.shreg[6:0], sda_now};
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            nxt_st.full = (st_ff.bit_cnt == 3'h7);
          end else if (scl_fall && st_ff.full) begin
            nxt_st.full = 1'b0;
            if (st_ff.i2c == I2C_ADDR) begin
              if (st_ff.shreg[7:1] == DEV_ADDR) begin
                nxt_st.sda_oe = 1'b1;
                nxt_st.rw = st_ff.shreg[0];
                nxt_st.i2c = I2C_AACK;
              end else begin
                nxt_st.i2c = I2C_IDLE;
              end
            end else begin
              nxt_st.sda_oe = 1'b1;
              nxt_st.i2c = I2C_WACK;
              if (st_ff.first) begin
                nxt_st.first = 1'b0;
                nxt_st.ptr = st_ff.shreg;
              end else begin
                nxt_st.ptr = st_ff.ptr + 8'h01;
                hit = cfg_lookup(st_ff.ptr);
                if (hit[4]) begin
                  if (!st_ff.boot) begin
                    nxt_st.cfg[hit[3:0]] = st_ff.shreg & CFG_MASK[hit[3:0]];
                  end
                end else if (st_ff.ptr == OFS_NVM_ADDRESS) begin
                  nxt_st.user_addr = st_ff.shreg[6:0];
                end else if (st_ff.ptr == OFS_NVM_CONTROL) begin
                  op_addr = st_ff.user_addr;
                  if (st_ff.shreg[NVM_ERR_BIT]) begin
                    nxt_st.err = 1'b0;
                  end
                  if (!st_ff.busy && st_ff.shreg[NVM_STORE_BIT]) begin
                    if (op_hit[4]) begin
                      nxt_st.nvm_wr = 1'b1;
                      nxt_st.nvm_a = op_addr;
                      nxt_st.nvm_wd = st_ff.cfg[op_hit[3:0]];
                      nxt_st.busy_cnt = BUSY_W'(NVM_WRITE_CYCLES);
                    end else begin
                      set_err = 1'b1;
                    end
                  end else if (!st_ff.busy && st_ff.shreg[NVM_RECALL_BIT]) begin
                    if (op_hit[4]) begin
                      nxt_st.nvm_rd = 1'b1;
                      nxt_st.nvm_a = op_addr;
                      nxt_st.recall = 1'b1;
                      nxt_st.idx = op_hit[3:0];
                    end else begin
                      set_err = 1'b1;
                    end
                  end
                end
                // Read-only readback and unmapped offsets take no write.
              end
            end
          end
        end
        I2C_AACK, I2C_WACK: begin
          if (scl_fall) begin
            nxt_st.bit_cnt = 3'h0;
            if (st_ff.i2c == I2C_AACK && st_ff.rw) begin
              rd_data = read_reg(st_ff, st_ff.ptr);
              nxt_st.shreg = rd_data;
              nxt_st.sda_oe = !rd_data[7];
              nxt_st.i2c = I2C_RD;
            end else begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.i2c = I2C_WR;
            end
          end
        end
        I2C_RD: begin
          if (scl_rise) begin
            nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
            nxt_st.full = (st_ff.bit_cnt == 3'h7);
          end else if (scl_fall) begin
            if (st_ff.full) begin
              nxt_st.full = 1'b0;
              nxt_st.sda_oe = 1'b0;
              nxt_st.i2c = I2C_RACK;
            end else begin
              nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
              nxt_st.sda_oe = !st_ff.shreg[6];
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            if (sda_now) begin
              nxt_st.i2c = I2C_IDLE;
            end else begin
              nxt_st.full = 1'b1;
            end
          end else if (scl_fall && st_ff.full) begin
            nxt_st.full = 1'b0;
            nxt_st.ptr = st_ff.ptr + 8'h01;
            rd_data = read_reg(st_ff, st_ff.ptr + 8'h01);
            nxt_st.shreg = rd_data;
            nxt_st.sda_oe = !rd_data[7];
            nxt_st.bit_cnt = 3'h0;
            nxt_st.i2c = I2C_RD;
          end
        end
      endcase
    end
    if (st_ff.boot) begin
      if (!st_ff.phase) begin
        nxt_st.nvm_rd = 1'b1;
        nxt_st.nvm_a = CFG_OFFSET[st_ff.idx][6:0];
        nxt_st.phase = 1'b1;
      end else begin
        nxt_st.cfg[st_ff.idx] = nvm_rdata & CFG_MASK[st_ff.idx];
        nxt_st.phase = 1'b0;
        nxt_st.idx = st_ff.idx + 4'h1;
        if (st_ff.idx == 4'(CFG_NUM - 1)) begin
          nxt_st.boot = 1'b0;
          nxt_st.idx = 4'h0;
        end
      end
    end else if (st_ff.recall) begin
      nxt_st.cfg[st_ff.idx] = nvm_rdata & CFG_MASK[st_ff.idx];
      nxt_st.recall = 1'b0;
    end
    if (set_err) begin
      nxt_st.err = 1'b1;
    end
    nxt_st.busy = nxt_st.boot || nxt_st.recall || (nxt_st.busy_cnt != '0);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.scl_s <= 3'h7;
      st_ff.sda_s <= 3'h7;
      st_ff.i2c <= I2C_IDLE;
      st_ff.cfg <= CFG_DEFAULT;
      st_ff.user_addr <= NVM_ADDRESS_RESET[6:0];
      st_ff.boot <= 1'b1;
      st_ff.busy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sda_out = st_ff.sda_out;
  assign sda_oe = st_ff.sda_oe;
  assign nvm_rd = st_ff.nvm_rd;
  assign nvm_wr = st_ff.nvm_wr;
  assign nvm_addr = st_ff.nvm_a;
  assign nvm_wdata = st_ff.nvm_wd;
  assign string_enable = st_ff.cfg[0];
  assign power_config = st_ff.cfg[1];
  assign oscillator_select = st_ff.cfg[2];
  assign overtemp_threshold = st_ff.cfg[3];
  assign system_temperature = st_ff.cfg[4];
  assign overtemp_derate_slope = st_ff.cfg[5];
  assign pulse_width_config = st_ff.cfg[6];
  assign global_brightness = st_ff.cfg[7];
  assign grayscale_clock_divider = st_ff.cfg[8];
  assign frame_sync_multiplier = st_ff.cfg[9];
  assign optimizer_monitor_low = st_ff.cfg[10];
  assign optimizer_monitor_high = st_ff.cfg[11];
  assign boot_load_active_flag = st_ff.boot;
  assign nvm_busy_flag = st_ff.busy;

endmodule
